// >>> rtl/ilc_pkg.sv
// Constants, register map and helper functions of the interrupt level control block.
package ilc_pkg;
  localparam int NSRC = 15;
  localparam int LVL_W = 2;
  localparam int ID_W = 4;
  localparam int FLOOR_W = 3;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int EVT_W = 3;
  localparam int LVLV_W = NSRC * LVL_W;
  // Byte addresses of the registers.
  localparam logic [15:0] ADDR_CTL_ON = 16'hF030;
  localparam logic [15:0] ADDR_IN_SERVICE = 16'hF032;
  localparam logic [15:0] ADDR_SEL_SUP = 16'hF034;
  localparam logic [15:0] ADDR_SEL_EXT = 16'hF036;
  localparam logic [15:0] ADDR_SEL_PER = 16'hF038;
  localparam logic [15:0] ADDR_EVT_STS = 16'hF040;
  localparam logic [15:0] ADDR_EVT_MASK = 16'hF042;
  // Implemented bits of each register; everything else reads as zero.
  localparam logic [15:0] WMASK_SUP = 16'h3000;
  localparam logic [15:0] WMASK_EXT = 16'hFFFF;
  localparam logic [15:0] WMASK_PER = 16'h33FF;
  localparam logic [7:0] CTL_ON_MASK = 8'h01;
  localparam logic [7:0] IN_SERVICE_MASK = 8'h8F;
  localparam logic [7:0] EVT_MASK_BITS = 8'h07;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Field positions.
  localparam int CTL_ON_BIT = 0;
  localparam int NMI_BIT = 7;
  localparam int SUP_LVL_LSB = 12;
  localparam int ADC_LVL_LSB = 12;
  localparam int SERB_LVL_LSB = 8;
  localparam int SERA_LVL_LSB = 6;
  localparam int MCU_LVL_LSB = 4;
  localparam int DMA_LVL_LSB = 2;
  localparam int CBU_LVL_LSB = 0;
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_RELEASE = 1;
  localparam int EVT_REFUSED = 2;
  // Byte enables and level encodings.
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [2:0] LVL_BASE = 3'h1;
  localparam logic [2:0] FLOOR_NONE = 3'h0;
  localparam logic [2:0] FLOOR_NMI = 3'h5;

  // Merges the enabled byte lanes of a write into the writable bits only.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [15:0] mask, input logic [1:0] be);
    logic [15:0] lane;
    lane = {{BYTE_W{be[1]}}, {BYTE_W{be[0]}}} & mask;
    return (old & ~lane) | (wd & lane);
  endfunction

  // One-hot of the highest level now marked in service.
  function automatic logic [7:0] highest_in_service(input logic [7:0] level_in_service);
    logic [7:0] hot;
    hot = RST_BYTE;
    if (level_in_service[NMI_BIT]) begin
      hot[NMI_BIT] = 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (level_in_service[i]) begin
          hot = RST_BYTE;
          hot[i] = 1'b1;
        end
      end
    end
    return hot;
  endfunction

  // Level number (1..4) now served, 5 for the non-maskable one, 0 for none.
  function automatic logic [2:0] service_floor(input logic [7:0] level_in_service);
    logic [2:0] f;
    f = FLOOR_NONE;
    for (int i = 0; i < 4; i++) begin
      if (level_in_service[i]) begin
        f = 3'(i) + LVL_BASE;
      end
    end
    if (level_in_service[NMI_BIT]) begin
      f = FLOOR_NMI;
    end
    return f;
  endfunction

  // Level field of one source out of the packed level vector.
  function automatic logic [1:0] field_level(input logic [LVLV_W-1:0] vec, input int idx);
    return vec[idx*LVL_W +: LVL_W];
  endfunction
endpackage

// >>> rtl/ilc_arbiter.sv
// Picks the request to present to the CPU and holds it in output registers.
`timescale 1ns/10ps
`default_nettype none
module ilc_arbiter
  import ilc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [NSRC-1:0] req_in,
  input wire logic [LVLV_W-1:0] lvl_in,
  input wire logic ctl_on_in,
  input wire logic [FLOOR_W-1:0] floor_in,
  output logic valid_out,
  output logic [ID_W-1:0] id_out,
  output logic [LVL_W-1:0] level_out
);
  logic found;
  logic [ID_W-1:0] best_id;
  logic [LVL_W-1:0] best_lv;
  logic [LVL_W-1:0] best_rank;

  // Scan from the top index down so that on a tie the lower index wins.
  always_comb begin
    logic [LVL_W-1:0] lv;
    logic [LVL_W-1:0] rank;
    logic ok;
    lv = '0;
    rank = '0;
    ok = 1'b0;
    found = 1'b0;
    best_id = '0;
    best_lv = '0;
    best_rank = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      lv = field_level(lvl_in, i);
      rank = ctl_on_in ? lv : '0;
      ok = !ctl_on_in || (({1'b0, lv} + LVL_BASE) >= floor_in);
      if (req_in[i] && ok && (!found || rank >= best_rank)) begin
        found = 1'b1;
        best_id = ID_W'(i);
        best_lv = lv;
        best_rank = rank;
      end
    end
  end

  // Registered so the CPU sees glitch-free choices; a change costs one cycle.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_out <= 1'b0;
      id_out <= '0;
      level_out <= '0;
    end else begin
      valid_out <= found;
      id_out <= best_id;
      level_out <= best_lv;
    end
  end
endmodule // ilc_arbiter
`default_nettype wire

// >>> rtl/ilc_level_ctrl.sv
// Interrupt priority level control: level registers, in-service tracking and request gating.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ilc_level_ctrl
  import ilc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_word_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [NSRC-1:0] src_req_in,
  input wire logic cpu_accept_in,
  input wire logic nmi_accept_in,
  output logic irq_valid_out,
  output logic [ID_W-1:0] irq_id_out,
  output logic [LVL_W-1:0] irq_level_out,
  output logic evt_irq_out
);
  logic [15:0] word_addr;
  logic [1:0] be;
  logic [15:0] wd16;
  logic hit_ctl, hit_cil, hit_sup, hit_ext, hit_per, hit_sts, hit_msk;
  logic ctl_on_ff;
  logic [7:0] in_svc_ff;
  logic [7:0] nxt_in_svc;
  logic [15:0] sel_sup_ff, sel_ext_ff, sel_per_ff;
  logic [EVT_W-1:0] evt_sts_ff, evt_msk_ff, evt_now;
  logic [LVLV_W-1:0] lvl_vec;
  logic [FLOOR_W-1:0] floor;
  logic accept_ms, nmi_set, clr, lvl_wr, lvl_refused;
  logic [7:0] set_vec;
  logic [15:0] nxt_rdata;

  // Byte accesses pick a lane from the low address bit; words ignore it.
  assign word_addr = {reg_addr_in[15:1], 1'b0};
  assign be = reg_word_in ? BE_WORD : (reg_addr_in[0] ? BE_HI : BE_LO);
  assign wd16 = reg_word_in ? reg_wdata_in : {reg_wdata_in[BYTE_W-1:0], reg_wdata_in[BYTE_W-1:0]};
  assign hit_ctl = (word_addr == ADDR_CTL_ON) && be[0];
  assign hit_cil = (word_addr == ADDR_IN_SERVICE) && be[0];
  assign hit_sup = (word_addr == ADDR_SEL_SUP);
  assign hit_ext = (word_addr == ADDR_SEL_EXT);
  assign hit_per = (word_addr == ADDR_SEL_PER);
  assign hit_sts = (word_addr == ADDR_EVT_STS) && be[0];
  assign hit_msk = (word_addr == ADDR_EVT_MASK) && be[0];
  assign lvl_wr = reg_wr_in && (hit_sup || hit_ext || hit_per);
  assign lvl_refused = lvl_wr && !ctl_on_ff;

  // Level control enable bit.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_on_ff <= 1'b0;
    end else if (reg_wr_in && hit_ctl) begin
      ctl_on_ff <= wd16[CTL_ON_BIT];
    end
  end

  // Level registers; only fields that exist are stored, the rest stay zero.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_sup_ff <= RST_WORD;
      sel_ext_ff <= RST_WORD;
      sel_per_ff <= RST_WORD;
    end else if (lvl_wr && ctl_on_ff) begin
      if (hit_sup) begin
        sel_sup_ff <= merge16(sel_sup_ff, wd16, WMASK_SUP, be);
      end
      if (hit_ext) begin
        sel_ext_ff <= merge16(sel_ext_ff, wd16, WMASK_EXT, be);
      end
      if (hit_per) begin
        sel_per_ff <= merge16(sel_per_ff, wd16, WMASK_PER, be);
      end
    end
  end

  // Source order: supervisor, pins 0..7, clock backup, DMA, MCU, serial a, serial b, ADC.
  assign lvl_vec = {sel_per_ff[ADC_LVL_LSB +: LVL_W], sel_per_ff[SERB_LVL_LSB +: LVL_W],
                    sel_per_ff[SERA_LVL_LSB +: LVL_W], sel_per_ff[MCU_LVL_LSB +: LVL_W],
                    sel_per_ff[DMA_LVL_LSB +: LVL_W], sel_per_ff[CBU_LVL_LSB +: LVL_W],
                    sel_ext_ff, sel_sup_ff[SUP_LVL_LSB +: LVL_W]};

  // Accepts mark levels only while level control is on; nothing else owns a level then.
  assign accept_ms = cpu_accept_in && irq_valid_out && ctl_on_ff;
  assign nmi_set = nmi_accept_in && ctl_on_ff;
  assign clr = reg_wr_in && hit_cil;

  always_comb begin
    set_vec = RST_BYTE;
    if (accept_ms) begin
      set_vec[irq_level_out] = 1'b1;
    end
    if (nmi_set) begin
      set_vec[NMI_BIT] = 1'b1;
    end
  end

  // The written value is ignored; a new mark in the same cycle survives the clear.
  assign nxt_in_svc = ((in_svc_ff & ~(clr ? highest_in_service(in_svc_ff) : RST_BYTE))
                      | set_vec) & IN_SERVICE_MASK;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_svc_ff <= RST_BYTE;
    end else begin
      in_svc_ff <= nxt_in_svc;
    end
  end

  assign floor = service_floor(in_svc_ff);

  ilc_arbiter u_arb (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .req_in(src_req_in),
    .lvl_in(lvl_vec),
    .ctl_on_in(ctl_on_ff),
    .floor_in(floor),
    .valid_out(irq_valid_out),
    .id_out(irq_id_out),
    .level_out(irq_level_out)
  );

  // Event flags: a new event in the cycle of its write-one clear wins.
  assign evt_now = {lvl_refused, clr && (in_svc_ff != RST_BYTE), accept_ms || nmi_set};

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_sts_ff <= '0;
    end else if (reg_wr_in && hit_sts) begin
      evt_sts_ff <= (evt_sts_ff & ~wd16[EVT_W-1:0]) | evt_now;
    end else begin
      evt_sts_ff <= evt_sts_ff | evt_now;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_msk_ff <= '0;
    end else if (reg_wr_in && hit_msk) begin
      evt_msk_ff <= wd16[EVT_W-1:0];
    end
  end

  // Registered interrupt line, one cycle behind the flags.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_irq_out <= 1'b0;
    end else begin
      evt_irq_out <= |(evt_sts_ff & evt_msk_ff);
    end
  end

  // Read mux; byte reads of the high lane come back in the low byte.
  always_comb begin
    logic [15:0] word;
    word = RST_WORD;
    case (word_addr)
      ADDR_CTL_ON: word = {RST_BYTE, {7'h00, ctl_on_ff} & CTL_ON_MASK};
      ADDR_IN_SERVICE: word = {RST_BYTE, in_svc_ff};
      ADDR_SEL_SUP: word = sel_sup_ff & WMASK_SUP;
      ADDR_SEL_EXT: word = sel_ext_ff;
      ADDR_SEL_PER: word = sel_per_ff & WMASK_PER;
      ADDR_EVT_STS: word = {RST_BYTE, {5'h00, evt_sts_ff} & EVT_MASK_BITS};
      ADDR_EVT_MASK: word = {RST_BYTE, {5'h00, evt_msk_ff} & EVT_MASK_BITS};
      default: word = RST_WORD;
    endcase
    if (!reg_word_in && reg_addr_in[0]) begin
      nxt_rdata = {RST_BYTE, word[WORD_W-1:BYTE_W]};
    end else if (!reg_word_in) begin
      nxt_rdata = {RST_BYTE, word[BYTE_W-1:0]};
    end else begin
      nxt_rdata = word;
    end
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= RST_WORD;
    end else begin
      reg_rdata_out <= reg_rd_in ? nxt_rdata : RST_WORD;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_accept;
    accept_ms && !clr;
  endsequence

  // An accept that marks a level not yet in service; an accept at an already marked level is not undone by one release.
  sequence s_accept_new;
    accept_ms && !clr && !in_svc_ff[irq_level_out];
  endsequence

  sequence s_release;
    clr && !accept_ms && !nmi_set && (in_svc_ff != RST_BYTE);
  endsequence

  AST_ACCEPT_SETS: assert property (s_accept |=> in_svc_ff[$past(irq_level_out)])
    else $error("accepted level not marked in service");
  AST_NMI_SETS: assert property (nmi_set |=> in_svc_ff[NMI_BIT])
    else $error("non-maskable accept not marked");
  AST_BLOCK_LOWER: assert property (irq_valid_out && $past(ctl_on_ff)
      |-> ({1'b0, irq_level_out} + LVL_BASE) >= $past(floor))
    else $error("request below served level presented");
  AST_NESTED_KEEP: assert property (s_accept |=> (in_svc_ff & $past(in_svc_ff)) == $past(in_svc_ff))
    else $error("nesting lost an in-service mark");
  AST_CLEAR_TOP: assert property (s_release |=> (in_svc_ff ^ $past(in_svc_ff))
      == highest_in_service($past(in_svc_ff)))
    else $error("release did not clear exactly the top mark");
  AST_ROUND_TRIP: assert property (s_accept_new ##1 s_release |=> in_svc_ff == $past(in_svc_ff, 2))
    else $error("accept then release did not restore the marks");
  AST_CIL_RSVD: assert property ((in_svc_ff & ~IN_SERVICE_MASK) == RST_BYTE)
    else $error("reserved in-service bits set");
  AST_LOCKED: assert property (lvl_refused |=> $stable(sel_sup_ff) && $stable(sel_ext_ff)
      && $stable(sel_per_ff))
    else $error("level register changed while control off");
  AST_RSVD_ZERO: assert property (((sel_sup_ff & ~WMASK_SUP) | (sel_per_ff & ~WMASK_PER)) == RST_WORD)
    else $error("reserved level bits set");
  AST_LEVEL_MATCH: assert property (irq_valid_out |-> irq_level_out
      == field_level($past(lvl_vec), int'(irq_id_out)))
    else $error("presented level differs from its field");
  AST_BYTE_HI: assert property (reg_wr_in && hit_ext && ctl_on_ff && !reg_word_in && reg_addr_in[0]
      |=> sel_ext_ff[BYTE_W-1:0] == $past(sel_ext_ff[BYTE_W-1:0]))
    else $error("high byte write touched low byte");
endmodule // ilc_level_ctrl
`default_nettype wire

// >>> verif/ilc_cpu_model.sv
// Behavioural CPU core that takes the presented interrupt after a chosen number of cycles.
`timescale 1ns/10ps
`default_nettype none
module ilc_cpu_model (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic take_in,
  input wire logic [3:0] lat_in,
  input wire logic irq_valid_in,
  output logic accept_out
);
  logic [3:0] wait_ff;
  logic done_ff;

  // One accept per raised take; the done flag hides the stale presentation that follows an accept.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
      accept_out <= 1'b0;
    end else if (!take_in) begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
      accept_out <= 1'b0;
    end else if (accept_out) begin
      accept_out <= 1'b0;
      done_ff <= 1'b1;
    end else if (!done_ff && irq_valid_in) begin
      if (wait_ff == lat_in) begin
        accept_out <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule // ilc_cpu_model
`default_nettype wire

// >>> verif/test_ilc_level_ctrl.sv
// Self-checking bench of the interrupt level control block with a CPU model on its far side.
`timescale 1ns/10ps
`default_nettype none
module test_ilc_level_ctrl
  import ilc_pkg::*;
;
  localparam logic [15:0] SEL_ADDR [3] = '{ADDR_SEL_SUP, ADDR_SEL_EXT, ADDR_SEL_PER};
  localparam logic [15:0] SEL_MASK [3] = '{WMASK_SUP, WMASK_EXT, WMASK_PER};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic word = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NSRC-1:0] req = 15'h0000;
  logic take = 1'b0;
  logic nmi = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [15:0] rdata;
  logic accept;
  logic valid;
  logic evt;
  logic [ID_W-1:0] id;
  logic [LVL_W-1:0] lvl;
  logic [15:0] expq [$];
  logic rd_pend = 1'b0;
  logic [31:0] seed = 32'h0001_3DCC;
  int j;
  int failures = 0;
  int cmp_count = 0;

  // Free-running system clock.
  initial begin
    forever #20 clk = ~clk;
  end

  ilc_level_ctrl dut_u (.clk_sys_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_word_in(word), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .src_req_in(req),
    .cpu_accept_in(accept), .nmi_accept_in(nmi), .irq_valid_out(valid), .irq_id_out(id),
    .irq_level_out(lvl), .evt_irq_out(evt));

  ilc_cpu_model cpu_u (.clk_sys_in(clk), .arst_n_in(arst_n), .take_in(take), .lat_in(lat),
    .irq_valid_in(valid), .accept_out(accept));

  // Next value of the fixed-seed pseudo-random sequence.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus cycle; a read notes its expected data for the monitor instead of checking it here.
  task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge clk);
    addr <= a;
    wdata <= r ? 16'h0000 : d;
    word <= w;
    wr <= !r;
    rd <= r;
    if (r) begin
      expq.push_back(d);
    end
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic chk_irq(input logic v, input logic [ID_W-1:0] i, input logic [LVL_W-1:0] l);
    cmp({15'h0000, valid}, {15'h0000, v});
    if (v) begin
      cmp({10'h000, lvl, id}, {10'h000, l, i});
    end
  endtask

  // Waits for the CPU model to take the presented request; a missing accept ends the run.
  task automatic wait_acc();
    int n;
    for (n = 0; n < 40 && accept !== 1'b1; n++) begin
      @(posedge clk);
    end
    if (n == 40) begin
      failures++;
      report_and_stop();
    end
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at that closing edge.
  always @(posedge clk) begin
    if (rd_pend) begin
      cmp(rdata, expq.pop_front());
    end
    rd_pend <= rd;
  end

  // A hang anywhere ends the run as a mismatch.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    acc(ADDR_CTL_ON, 16'h0000, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) acc(SEL_ADDR[i], RST_WORD, 1'b1, 1'b1);
    acc(ADDR_IN_SERVICE, RST_WORD, 1'b0, 1'b1);
    $display("test reset values done");
    // Level writes with control off must vanish and flag a refusal event.
    acc(ADDR_SEL_EXT, 16'hFFFF, 1'b1, 1'b0);
    acc(ADDR_SEL_EXT, RST_WORD, 1'b1, 1'b1);
    acc(ADDR_EVT_STS, 16'h0004, 1'b1, 1'b1);
    tick(3);
    cmp({15'h0000, evt}, 16'h0000);
    acc(ADDR_EVT_MASK, 16'h0004, 1'b1, 1'b0);
    tick(3);
    cmp({15'h0000, evt}, 16'h0001);
    acc(ADDR_EVT_STS, 16'h0004, 1'b1, 1'b0);
    tick(3);
    cmp({15'h0000, evt}, 16'h0000);
    // Control on; level writes happen with no request pending and the CPU not taking.
    acc(ADDR_CTL_ON, 16'h0001, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      acc(SEL_ADDR[i], 16'hFFFF, 1'b1, 1'b0);
      acc(SEL_ADDR[i], SEL_MASK[i], 1'b1, 1'b1);
    end
    acc(ADDR_SEL_EXT + 16'h0001, 16'h00A5, 1'b0, 1'b0);
    acc(ADDR_SEL_EXT, 16'hA5FF, 1'b1, 1'b1);
    acc(ADDR_SEL_EXT, 16'h003C, 1'b0, 1'b0);
    acc(ADDR_SEL_EXT + 16'h0001, 16'h00A5, 1'b0, 1'b1);
    acc(ADDR_SEL_EXT, 16'h003C, 1'b0, 1'b1);
    acc(16'hF03A, 16'h0000, 1'b1, 1'b1);
    $display("test register map done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      j = int'(seed % 32'h0000_0003);
      acc(SEL_ADDR[j], seed[31:16], 1'b1, 1'b0);
      acc(SEL_ADDR[j], seed[31:16] & SEL_MASK[j], 1'b1, 1'b1);
    end
    $display("test random levels done");
    // Supervisor at level 1, pin 0 at level 3, pin 1 at level 4.
    acc(ADDR_SEL_SUP, 16'h0000, 1'b1, 1'b0);
    acc(ADDR_SEL_EXT, 16'h000E, 1'b1, 1'b0);
    req <= 15'h0003;
    tick(3);
    chk_irq(1'b1, 4'h1, 2'b10);
    take <= 1'b1;
    wait_acc();
    req <= 15'h0001;
    take <= 1'b0;
    tick(3);
    chk_irq(1'b0, 4'h0, 2'b00);
    acc(ADDR_IN_SERVICE, 16'h0004, 1'b0, 1'b1);
    lat <= 4'h3;
    req <= 15'h0005;
    tick(3);
    chk_irq(1'b1, 4'h2, 2'b11);
    take <= 1'b1;
    wait_acc();
    req <= 15'h0001;
    take <= 1'b0;
    acc(ADDR_IN_SERVICE, 16'h000C, 1'b0, 1'b1);
    acc(ADDR_IN_SERVICE, 16'hFFFF, 1'b0, 1'b0);
    acc(ADDR_IN_SERVICE, 16'h0004, 1'b0, 1'b1);
    tick(3);
    chk_irq(1'b0, 4'h0, 2'b00);
    acc(ADDR_IN_SERVICE, 16'h0000, 1'b0, 1'b0);
    acc(ADDR_IN_SERVICE, 16'h0000, 1'b0, 1'b1);
    tick(3);
    chk_irq(1'b1, 4'h0, 2'b00);
    $display("test nesting done");
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    acc(ADDR_IN_SERVICE, 16'h0080, 1'b0, 1'b1);
    tick(2);
    chk_irq(1'b0, 4'h0, 2'b00);
    acc(ADDR_IN_SERVICE, 16'h0055, 1'b0, 1'b0);
    acc(ADDR_IN_SERVICE, 16'h0000, 1'b0, 1'b1);
    tick(3);
    chk_irq(1'b1, 4'h0, 2'b00);
    acc(ADDR_EVT_STS, 16'h0003, 1'b1, 1'b1);
    req <= 15'h0000;
    tick(3);
    $display("test non-maskable done");
    report_and_stop();
  end
endmodule // test_ilc_level_ctrl
`default_nettype wire
